/* File: rtl/pmr_pkg.sv */
// Constants and types for the power-management register bank
package pmr_pkg;

    // Register byte addresses (low address byte)
    localparam logic [7:0] OFF_CAPS = 8'hA0;
    localparam logic [7:0] OFF_POWER_STATE_CONTROL_STATUS = 8'hA4;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'hA8;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hAC;

    // Capability field positions and fixed values
    localparam int CAP_LIGHT_SLEEP_BIT = 9;
    localparam int CAP_RSVD_LSB = 6;
    localparam int CAP_DSI_BIT = 5;
    localparam int CAP_AUX_BIT = 4;
    localparam int CAP_CLK_BIT = 3;
    localparam int CAP_VER_LSB = 0;
    localparam logic [2:0] CAP_VERSION = 3'h2;

    // Control/status field positions
    localparam int CSR_WES_BIT = 15;
    localparam int CSR_WAE_BIT = 8;
    localparam int CSR_PSF_LSB = 0;

    // Power states
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3HOT = 2'h3;

    // Interrupt bits
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_D0_ENTRY_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Control/status register layout
    typedef struct packed {
        logic wake_event_status;
        logic [1:0] data_scale_field;
        logic [3:0] data_select_field;
        logic wake_assert_enable;
        logic [5:0] reserved;
        logic [1:0] power_state_field;
    } pmr_csr_t;

    localparam pmr_csr_t CSR_RESET = 16'h0000;

    // Bus sequencer states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RDWAIT = 2'b10
    } pmr_bus_state_t;

endpackage

/* File: rtl/pmr_power_mgmt_regs.sv */
// Power-management capability and control/status registers behind an AHB-Lite slave
//
// How it works
// - The light-sleep support bit of the capability register always reads one.
// - Capability bits eight to six always read zero.
// - The device-specific initialization bit always reads zero.
// - The auxiliary power bit is read-only and reads zero whenever cold-state wake is not supported.
// - The wake-needs-clock bit is read-only and fixed for a function that can signal wake.
// - The version field always reads the pattern 010.
// - Writing D0 while in D3hot raises a one-cycle internal reset for the rest of the function.
// - The control/status register keeps its contents across that internal reset.
// - A wake event sets the wake status bit whatever the wake enable says.
// - Writing one to wake status clears it and drops the wake output; writing zero does nothing.
// - Data scale and data select fields always read zero.
// - Wake enable gates the wake output; a write loads it from bit eight, the global reset or reset_n clears it, and the bus reset leaves it.
// - Control/status bits seven to two always read zero.
// - The power-state field reads the current state and a write moves to the written state.
// - Wake status survives bus reset while wake is enabled, otherwise either reset clears it.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
module pmr_power_mgmt_regs #(
    parameter logic AUX_POWER_FROM_SYSTEM = 1'b1,
    parameter logic WAKE_NEEDS_CLOCK = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Device side
    input wire logic global_reset_n,
    input wire logic primary_bus_reset_n,
    input wire logic wake_event_request,
    input wire logic d3cold_wake_capable,
    output logic wake_event_signal_n,
    output logic [1:0] power_state_field,
    output logic internal_reset,
    output logic irq
);

    // Reset synchroniser
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    function automatic logic pmr_hit(input logic [7:0] addr, input logic [7:0] off);
        pmr_hit = (addr == off);
    endfunction

    // State
    pmr_pkg::pmr_csr_t csr_ff, nxt_csr;
    logic [1:0] irq_status_ff, nxt_irq_status;
    logic [1:0] irq_mask_ff, nxt_irq_mask;
    logic wake_n_ff, nxt_wake_n;
    logic irq_ff, nxt_irq;
    logic intrst_ff, nxt_intrst;
    pmr_pkg::pmr_bus_state_t bus_state_ff, nxt_bus_state;
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_addr_ff, nxt_wr_addr;
    logic [7:0] rd_addr_ff, nxt_rd_addr;
    logic hreadyout_ff, nxt_hreadyout;
    logic [31:0] hrdata_ff, nxt_hrdata;

    logic wr_csr;
    logic wr_mask;
    logic rd_clear;
    logic d0_entry;
    logic [15:0] caps_word;

    // Capability word
    always_comb begin
        caps_word = 16'h0000;
        caps_word[pmr_pkg::CAP_LIGHT_SLEEP_BIT] = 1'b1;
        caps_word[pmr_pkg::CAP_RSVD_LSB +: 3] = 3'h0;
        caps_word[pmr_pkg::CAP_DSI_BIT] = 1'b0;
        caps_word[pmr_pkg::CAP_AUX_BIT] = AUX_POWER_FROM_SYSTEM & d3cold_wake_capable;
        caps_word[pmr_pkg::CAP_CLK_BIT] = WAKE_NEEDS_CLOCK;
        caps_word[pmr_pkg::CAP_VER_LSB +: 3] = pmr_pkg::CAP_VERSION;
    end

    // Register next values
    always_comb begin
        nxt_csr = csr_ff;
        nxt_irq_status = irq_status_ff;
        nxt_irq_mask = irq_mask_ff;
        wr_csr = wr_pend_ff && pmr_hit(wr_addr_ff, pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS);
        wr_mask = wr_pend_ff && pmr_hit(wr_addr_ff, pmr_pkg::OFF_IRQ_MASK);
        rd_clear = (bus_state_ff == pmr_pkg::BUS_RDWAIT) && pmr_hit(rd_addr_ff, pmr_pkg::OFF_IRQ_STATUS);
        d0_entry = wr_csr && (csr_ff.power_state_field == pmr_pkg::PS_D3HOT)
            && (hwdata[pmr_pkg::CSR_PSF_LSB +: 2] == pmr_pkg::PS_D0);
        if (wr_csr) begin
            nxt_csr.power_state_field = hwdata[pmr_pkg::CSR_PSF_LSB +: 2];
            nxt_csr.wake_assert_enable = hwdata[pmr_pkg::CSR_WAE_BIT];
            if (hwdata[pmr_pkg::CSR_WES_BIT]) begin
                nxt_csr.wake_event_status = 1'b0;
            end
        end
        if (wake_event_request) begin
            nxt_csr.wake_event_status = 1'b1;
        end
        if (!primary_bus_reset_n) begin
            nxt_csr.power_state_field = pmr_pkg::PS_D0;
            if (!csr_ff.wake_assert_enable) begin
                nxt_csr.wake_event_status = 1'b0;
            end
        end
        if (!global_reset_n) begin
            nxt_csr = pmr_pkg::CSR_RESET;
        end
        nxt_intrst = d0_entry && global_reset_n && primary_bus_reset_n;
        // Internal reset leaves the control/status register alone
        if (rd_clear) begin
            nxt_irq_status = pmr_pkg::IRQ_RESET;
        end
        if (wr_mask) begin
            nxt_irq_mask = hwdata[1:0];
        end
        if (wake_event_request) begin
            nxt_irq_status[pmr_pkg::IRQ_WAKE_BIT] = 1'b1;
        end
        if (nxt_intrst) begin
            nxt_irq_status[pmr_pkg::IRQ_D0_ENTRY_BIT] = 1'b1;
        end
        nxt_wake_n = !(nxt_csr.wake_event_status && nxt_csr.wake_assert_enable);
        nxt_irq = |(nxt_irq_status & nxt_irq_mask);
    end

    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            csr_ff <= pmr_pkg::CSR_RESET;
            irq_status_ff <= pmr_pkg::IRQ_RESET;
            irq_mask_ff <= pmr_pkg::IRQ_RESET;
            wake_n_ff <= 1'b1;
            irq_ff <= 1'b0;
            intrst_ff <= 1'b0;
        end else begin
            csr_ff <= nxt_csr;
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
            wake_n_ff <= nxt_wake_n;
            irq_ff <= nxt_irq;
            intrst_ff <= nxt_intrst;
        end
    end

    // Bus sequencer next values
    always_comb begin
        nxt_bus_state = bus_state_ff;
        nxt_wr_pend = 1'b0;
        nxt_wr_addr = wr_addr_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_hreadyout = hreadyout_ff;
        nxt_hrdata = hrdata_ff;
        case (bus_state_ff)
            pmr_pkg::BUS_IDLE: begin
                nxt_hreadyout = 1'b1;
                if (hsel && htrans[1] && hready) begin
                    if (hwrite) begin
                        nxt_wr_pend = 1'b1;
                        nxt_wr_addr = haddr[7:0];
                    end else begin
                        nxt_rd_addr = haddr[7:0];
                        nxt_hreadyout = 1'b0;
                        nxt_bus_state = pmr_pkg::BUS_RDWAIT;
                    end
                end
            end
            pmr_pkg::BUS_RDWAIT: begin
                nxt_hrdata = 32'h0000_0000;
                if (pmr_hit(rd_addr_ff, pmr_pkg::OFF_CAPS)) begin
                    nxt_hrdata[15:0] = caps_word;
                end else if (pmr_hit(rd_addr_ff, pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS)) begin
                    nxt_hrdata[15:0] = csr_ff;
                end else if (pmr_hit(rd_addr_ff, pmr_pkg::OFF_IRQ_STATUS)) begin
                    nxt_hrdata[1:0] = irq_status_ff;
                end else if (pmr_hit(rd_addr_ff, pmr_pkg::OFF_IRQ_MASK)) begin
                    nxt_hrdata[1:0] = irq_mask_ff;
                end
                nxt_hreadyout = 1'b1;
                nxt_bus_state = pmr_pkg::BUS_IDLE;
            end
            default: begin
                nxt_hreadyout = 1'b1;
                nxt_bus_state = pmr_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            bus_state_ff <= pmr_pkg::BUS_IDLE;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rd_addr_ff <= 8'h00;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            bus_state_ff <= nxt_bus_state;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rd_addr_ff <= nxt_rd_addr;
            hreadyout_ff <= nxt_hreadyout;
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Outputs
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0 & hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign wake_event_signal_n = wake_n_ff;
    assign power_state_field = csr_ff.power_state_field;
    assign internal_reset = intrst_ff;
    assign irq = irq_ff;

    // Checks
    logic rd_caps;
    logic rd_csr;
    assign rd_caps = (bus_state_ff == pmr_pkg::BUS_RDWAIT) && pmr_hit(rd_addr_ff, pmr_pkg::OFF_CAPS);
    assign rd_csr = (bus_state_ff == pmr_pkg::BUS_RDWAIT) && pmr_hit(rd_addr_ff, pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS);

    property p_light_sleep;
        @(posedge clock) disable iff (!rst_sync_ff) rd_caps |=> hreadyout_ff && hrdata_ff[9];
    endproperty
    a_light_sleep: assert property (p_light_sleep) else $error("light sleep bit not one");

    property p_caps_rsvd;
        @(posedge clock) disable iff (!rst_sync_ff) rd_caps |=> hrdata_ff[8:6] == 3'h0;
    endproperty
    a_caps_rsvd: assert property (p_caps_rsvd) else $error("capability reserved bits not zero");

    property p_dsi;
        @(posedge clock) disable iff (!rst_sync_ff) rd_caps |=> !hrdata_ff[5];
    endproperty
    a_dsi: assert property (p_dsi) else $error("init bit not zero");

    property p_aux;
        @(posedge clock) disable iff (!rst_sync_ff) rd_caps && !d3cold_wake_capable |=> !hrdata_ff[4];
    endproperty
    a_aux: assert property (p_aux) else $error("aux power bit set without cold wake");

    property p_wake_clk;
        @(posedge clock) disable iff (!rst_sync_ff) rd_caps |=> hrdata_ff[3] == WAKE_NEEDS_CLOCK;
    endproperty
    a_wake_clk: assert property (p_wake_clk) else $error("wake clock bit wrong");

    property p_version;
        @(posedge clock) disable iff (!rst_sync_ff) rd_caps |=> hrdata_ff[2:0] == 3'h2;
    endproperty
    a_version: assert property (p_version) else $error("version field wrong");

    property p_d0_entry;
        @(posedge clock) disable iff (!rst_sync_ff)
            wr_csr && csr_ff.power_state_field == 2'h3 && hwdata[1:0] == 2'h0
            && global_reset_n && primary_bus_reset_n |=> internal_reset ##1 !internal_reset;
    endproperty
    a_d0_entry: assert property (p_d0_entry) else $error("no one-cycle internal reset on D3hot to D0");

    property p_csr_kept;
        @(posedge clock) disable iff (!rst_sync_ff)
            internal_reset && global_reset_n && primary_bus_reset_n && !wr_csr && !wake_event_request
            |-> power_state_field == 2'h0 && csr_ff.wake_assert_enable == $past(hwdata[8]) ##1 $stable(csr_ff);
    endproperty
    a_csr_kept: assert property (p_csr_kept) else $error("control/status lost on internal reset");

    property p_wake_set;
        @(posedge clock) disable iff (!rst_sync_ff)
            wake_event_request && global_reset_n && (primary_bus_reset_n || csr_ff.wake_assert_enable)
            |=> csr_ff.wake_event_status;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake status not set by event");

    property p_wake_clear;
        @(posedge clock) disable iff (!rst_sync_ff)
            wr_csr && hwdata[15] && !wake_event_request |=> !csr_ff.wake_event_status && wake_event_signal_n;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("write one did not clear wake");

    property p_wake_keep;
        @(posedge clock) disable iff (!rst_sync_ff)
            wr_csr && !hwdata[15] && csr_ff.wake_event_status && global_reset_n
            && (primary_bus_reset_n || csr_ff.wake_assert_enable) |=> csr_ff.wake_event_status;
    endproperty
    a_wake_keep: assert property (p_wake_keep) else $error("write zero changed wake status");

    property p_data_fields;
        @(posedge clock) disable iff (!rst_sync_ff) rd_csr |=> hrdata_ff[14:9] == 6'h00;
    endproperty
    a_data_fields: assert property (p_data_fields) else $error("data fields not zero");

    property p_enable_global_reset;
        @(posedge clock) disable iff (!rst_sync_ff)
            !global_reset_n |=> !csr_ff.wake_assert_enable && !csr_ff.wake_event_status;
    endproperty
    a_enable_global_reset: assert property (p_enable_global_reset) else $error("global reset did not clear");

    property p_enable_primary_bus_reset;
        @(posedge clock) disable iff (!rst_sync_ff)
            !primary_bus_reset_n && global_reset_n && !wr_csr |=> $stable(csr_ff.wake_assert_enable);
    endproperty
    a_enable_primary_bus_reset: assert property (p_enable_primary_bus_reset) else $error("bus reset touched wake enable");

    property p_csr_rsvd;
        @(posedge clock) disable iff (!rst_sync_ff) rd_csr |=> hrdata_ff[7:2] == 6'h00 && hrdata_ff[31:16] == 16'h0000;
    endproperty
    a_csr_rsvd: assert property (p_csr_rsvd) else $error("reserved control bits not zero");

    property p_state_write;
        @(posedge clock) disable iff (!rst_sync_ff)
            wr_csr && global_reset_n && primary_bus_reset_n |=> power_state_field == $past(hwdata[1:0]);
    endproperty
    a_state_write: assert property (p_state_write) else $error("power state write lost");

    property p_wake_primary_bus_reset;
        @(posedge clock) disable iff (!rst_sync_ff)
            !primary_bus_reset_n && global_reset_n && csr_ff.wake_assert_enable && csr_ff.wake_event_status
            && !wr_csr |=> csr_ff.wake_event_status;
    endproperty
    a_wake_primary_bus_reset: assert property (p_wake_primary_bus_reset) else $error("wake status lost on bus reset while enabled");

    property p_wake_out;
        @(posedge clock) disable iff (!rst_sync_ff)
            wake_event_signal_n == !(csr_ff.wake_event_status && csr_ff.wake_assert_enable);
    endproperty
    a_wake_out: assert property (p_wake_out) else $error("wake output disagrees with status and enable");

    property p_wake_assert;
        @(posedge clock) disable iff (!rst_sync_ff)
            wake_event_request && csr_ff.wake_assert_enable && global_reset_n && !wr_csr |=> !wake_event_signal_n;
    endproperty
    a_wake_assert: assert property (p_wake_assert) else $error("enabled wake event did not drive wake low");

    property p_read_wait;
        @(posedge clock) disable iff (!rst_sync_ff)
            hsel && htrans[1] && hready && !hwrite && hreadyout_ff |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read did not take exactly one wait cycle");

    property p_write_nowait;
        @(posedge clock) disable iff (!rst_sync_ff)
            hsel && htrans[1] && hready && hwrite && hreadyout_ff |=> hreadyout && wr_pend_ff;
    endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled the bus");

    property p_irq_event;
        @(posedge clock) disable iff (!rst_sync_ff)
            wake_event_request && irq_mask_ff[0] && !wr_mask |=> irq;
    endproperty
    a_irq_event: assert property (p_irq_event) else $error("unmasked wake event did not raise irq");

    property p_status_rdclr;
        @(posedge clock) disable iff (!rst_sync_ff)
            rd_clear && !wake_event_request && !wr_csr |=> irq_status_ff == 2'h0;
    endproperty
    a_status_rdclr: assert property (p_status_rdclr) else $error("status read did not clear");

    property p_d0_irq;
        @(posedge clock) disable iff (!rst_sync_ff) internal_reset |-> irq_status_ff[1];
    endproperty
    a_d0_irq: assert property (p_d0_irq) else $error("D0 entry not flagged in status");

endmodule // pmr_power_mgmt_regs

/* File: tb/pmr_power_mgmt_regs_test.sv */
// Self-checking bench for the power-management register bank
`timescale 1ns/100ps
`define CHECK(name, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
end
module pmr_power_mgmt_regs_test;
    // Clock, reset and bus
    logic clock;
    logic reset_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    // Device side
    logic global_reset_n;
    logic primary_bus_reset_n;
    logic wake_event_request;
    logic d3cold_wake_capable;
    logic wake_event_signal_n;
    logic [1:0] power_state_field;
    logic internal_reset;
    logic irq;
    // Bench state
    int err_count = 0;
    int total_checks = 0;
    int reset_pulses = 0;
    logic [31:0] rdata;

    assign hready = hreadyout;

    pmr_power_mgmt_regs #(
        .AUX_POWER_FROM_SYSTEM(1'b1),
        .WAKE_NEEDS_CLOCK(1'b0)
    ) pmr_power_mgmt_regs_inst (
        .clock(clock),
        .reset_n(reset_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .global_reset_n(global_reset_n),
        .primary_bus_reset_n(primary_bus_reset_n),
        .wake_event_request(wake_event_request),
        .d3cold_wake_capable(d3cold_wake_capable),
        .wake_event_signal_n(wake_event_signal_n),
        .power_state_field(power_state_field),
        .internal_reset(internal_reset),
        .irq(irq)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Internal reset pulse counter
    always @(posedge clock) begin
        if (internal_reset === 1'b1) begin
            reset_pulses <= reset_pulses + 1;
        end
    end

    task complete_run;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task wait_ready;
        int n;
        n = 0;
        @(posedge clock);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                $display("ERROR hready expected 1 seen stalled");
                complete_run();
            end
            @(posedge clock);
        end
    endtask

    task bus_access(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= is_wr;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rdata = hrdata;
        `CHECK("hresp", 1'b0, hresp)
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus_access(1'b1, a, d);
    endtask

    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus_access(1'b0, a, 32'h00000000);
        `CHECK(name, exp, rdata)
    endtask

    task settle;
        repeat (3) @(negedge clock);
    endtask

    task fire_event;
        @(posedge clock);
        wake_event_request <= 1'b1;
        @(posedge clock);
        wake_event_request <= 1'b0;
        settle();
    endtask

    task pulse_reset(input logic glob);
        @(posedge clock);
        if (glob) begin
            global_reset_n <= 1'b0;
        end else begin
            primary_bus_reset_n <= 1'b0;
        end
        @(posedge clock);
        global_reset_n <= 1'b1;
        primary_bus_reset_n <= 1'b1;
        settle();
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("ERROR run expected done seen running");
        complete_run();
    end

    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        global_reset_n = 1'b1;
        primary_bus_reset_n = 1'b1;
        wake_event_request = 1'b0;
        d3cold_wake_capable = 1'b1;
        repeat (20) @(posedge clock);
        `CHECK("wake_n_rst", 1'b1, wake_event_signal_n)
        `CHECK("state_rst", pmr_pkg::PS_D0, power_state_field)
        `CHECK("irq_rst", 1'b0, irq)
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        // Capability word and unmapped space
        rd_chk("caps", pmr_pkg::OFF_CAPS, 32'h00000212);
        rd_chk("csr_rst", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000000);
        rd_chk("mask_rst", pmr_pkg::OFF_IRQ_MASK, 32'h00000000);
        d3cold_wake_capable <= 1'b0;
        rd_chk("caps_nocold", pmr_pkg::OFF_CAPS, 32'h00000202);
        d3cold_wake_capable <= 1'b1;
        wr(pmr_pkg::OFF_CAPS, 32'hFFFFFFFF);
        rd_chk("caps_ro", pmr_pkg::OFF_CAPS, 32'h00000212);
        wr(8'hB0, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'hB0, 32'h00000000);
        // Every power state, read-only bits written as ones
        for (int s = 0; s < 4; s++) begin
            wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00007EFC | 32'(s));
            rd_chk("csr_state", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'(s));
            `CHECK("state_port", 2'(s), power_state_field)
        end
        // Only D3hot to D0 pulses the internal reset
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000000);
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000002);
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000000);
        settle();
        `CHECK("int_reset_count", 1, reset_pulses)
        rd_chk("irq_stat_d0", pmr_pkg::OFF_IRQ_STATUS, 32'h00000002);
        rd_chk("irq_stat_clr", pmr_pkg::OFF_IRQ_STATUS, 32'h00000000);
        // Wake status, enable and output
        fire_event();
        rd_chk("csr_wake_dis", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00008000);
        `CHECK("wake_n_dis", 1'b1, wake_event_signal_n)
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000100);
        settle();
        `CHECK("wake_n_en", 1'b0, wake_event_signal_n)
        rd_chk("csr_w0", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00008100);
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00008100);
        settle();
        `CHECK("wake_n_clr", 1'b1, wake_event_signal_n)
        rd_chk("csr_w1", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000100);
        rd_chk("irq_stat_wake", pmr_pkg::OFF_IRQ_STATUS, 32'h00000001);
        // Register kept across the internal reset
        fire_event();
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000103);
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000100);
        settle();
        `CHECK("int_reset_count2", 2, reset_pulses)
        rd_chk("csr_kept", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00008100);
        `CHECK("wake_n_kept", 1'b0, wake_event_signal_n)
        // Bus reset and global reset
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000101);
        pulse_reset(1'b0);
        rd_chk("csr_bus_en", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00008100);
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000000);
        pulse_reset(1'b0);
        rd_chk("csr_bus_dis", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000000);
        wr(pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000101);
        fire_event();
        pulse_reset(1'b1);
        rd_chk("csr_glob", pmr_pkg::OFF_POWER_STATE_CONTROL_STATUS, 32'h00000000);
        `CHECK("wake_n_glob", 1'b1, wake_event_signal_n)
        // Interrupt status, mask and output
        rd_chk("irq_stat_all", pmr_pkg::OFF_IRQ_STATUS, 32'h00000003);
        wr(pmr_pkg::OFF_IRQ_MASK, 32'h00000003);
        rd_chk("mask_set", pmr_pkg::OFF_IRQ_MASK, 32'h00000003);
        `CHECK("irq_idle", 1'b0, irq)
        fire_event();
        `CHECK("irq_on", 1'b1, irq)
        rd_chk("irq_stat_one", pmr_pkg::OFF_IRQ_STATUS, 32'h00000001);
        settle();
        `CHECK("irq_off", 1'b0, irq)
        wr(pmr_pkg::OFF_IRQ_MASK, 32'h00000000);
        fire_event();
        `CHECK("irq_masked", 1'b0, irq)
        rd_chk("irq_stat_mask", pmr_pkg::OFF_IRQ_STATUS, 32'h00000001);
        complete_run();
    end
endmodule // pmr_power_mgmt_regs_test
